// ---- shared/pit_pkg.sv ----
// Package for the periodic interrupt timer: register map, field positions,
// reset values and the AXI4-Lite carrier types.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses in 8 bits.
package pit_pkg;

  localparam int unsigned PIT_NUM_CH   = 8;
  localparam int unsigned PIT_NUM_TRIG = 4;
  localparam int unsigned PIT_NUM_MT   = 2;
  localparam int unsigned PIT_CNT_W    = 16;
  localparam int unsigned PIT_MT_W     = 8;
  localparam int unsigned PIT_ADDR_W   = 8;

  // Register byte offsets
  localparam logic [7:0] PIT_OFS_CTRL    = 8'h00; // module_control_register
  localparam logic [7:0] PIT_OFS_FORCE   = 8'h04; // force_load_register
  localparam logic [7:0] PIT_OFS_CHEN    = 8'h08; // channel_enable
  localparam logic [7:0] PIT_OFS_MUX     = 8'h0c; // micro timer select
  localparam logic [7:0] PIT_OFS_IE      = 8'h10; // irq_enable_register
  localparam logic [7:0] PIT_OFS_FLAG    = 8'h14; // timeout_flag_register
  localparam logic [7:0] PIT_OFS_MTLD0   = 8'h18; // micro_timer_load 0
  localparam logic [7:0] PIT_OFS_MTLD1   = 8'h1c; // micro_timer_load 1
  localparam logic [7:0] PIT_OFS_LD_BASE = 8'h20; // channel_load_register 0..7
  localparam logic [7:0] PIT_OFS_CNT_BASE = 8'h40; // channel_count_register 0..7
  localparam logic [7:0] PIT_OFS_END     = 8'h60;

  // Field positions in module_control_register
  localparam int unsigned PIT_CTRL_EN_BIT  = 7;
  localparam int unsigned PIT_CTRL_FLMT_LO = 0;

  // Reset values
  localparam logic [15:0] PIT_LD_RST   = 16'h0000;
  localparam logic [7:0]  PIT_MTLD_RST = 8'h00;
  localparam logic [7:0]  PIT_BYTE_RST = 8'h00;

  localparam logic [1:0] PIT_RESP_OKAY   = 2'b00;
  localparam logic [1:0] PIT_RESP_SLVERR = 2'b10;

  // A write whose address and data halves have both arrived
  typedef struct packed {
    logic [PIT_ADDR_W-1:0] addr;
    logic [31:0]           data;
    logic [3:0]            strb;
  } pit_wr_t;

endpackage : pit_pkg

// ---- hdl/pit_chan.sv ----
// One 16-bit modulus down-counter channel of the periodic timer.
// Assumes tick is a one-cycle time base strobe already gated by the enables.
`timescale 1ns/100ps
module pit_chan
  import pit_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 srst,
  input  wire logic                 tick,
  input  wire logic                 force_load,
  input  wire logic [PIT_CNT_W-1:0] load_val,
  output logic      [PIT_CNT_W-1:0] count,
  output logic                      timeout
);

  logic [PIT_CNT_W-1:0] count_r;

  // A force load takes priority and swallows a coinciding time-out
  assign timeout = tick & ~force_load & (count_r == '0);
  assign count   = count_r;

  always_ff @(posedge mclk) begin
    if (srst) begin
      count_r <= PIT_LD_RST;
    end else if (force_load) begin
      count_r <= load_val;
    end else if (tick) begin
      if (count_r == '0) begin
        count_r <= load_val;
      end else begin
        count_r <= count_r - 16'h0001;
      end
    end
  end

endmodule : pit_chan

// ---- hdl/pit_top.sv ----
// Periodic interrupt timer: eight down-counter channels fed by two micro
// timers, four hardware trigger lines, and an AXI4-Lite register slave.
// Assumes a single 10 MHz clock mclk and a synchronous active-high srst.
//
// Functional notes
// - Each channel keeps a 16-bit load value giving its counter modulus.
// - Writing a load value never restarts the counter; used at next reload.
// - Counter at zero sets the channel flag and reloads from load value.
// - Force-load bit copies the load value into the counter at once.
// - Per-channel interrupt enable requests interrupt while its flag is set.
// - Writing one clears a time-out flag; writing zero leaves it.
// - Four hardware trigger outputs, one per channel zero to three.
// - Each time-out of a trigger channel sets its flag and raises its trigger.
// - Trigger stays high one clock; software uses periods of two or more.
// - Clearing channel, interrupt or module enable clears matching flags.
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps
module pit_top
  import pit_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    srst,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [PIT_ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]              s_axi_awprot,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  output logic      [1:0]              s_axi_bresp,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  input  wire logic [PIT_ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]              s_axi_arprot,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  output logic      [31:0]             s_axi_rdata,
  output logic      [1:0]              s_axi_rresp,
  output logic      [PIT_NUM_TRIG-1:0] hw_trigger_out,
  output logic                         irq
);

  // Word index of a byte address, used by the write decode
  function automatic logic [5:0] word_idx(input logic [PIT_ADDR_W-1:0] a);
    word_idx = a[7:2];
  endfunction : word_idx

  function automatic logic mapped(input logic [PIT_ADDR_W-1:0] a);
    mapped = (a < PIT_OFS_END);
  endfunction : mapped

  // Configuration and status state
  logic                       module_enable_r;
  logic [PIT_NUM_CH-1:0]      channel_enable_r;
  logic [PIT_NUM_CH-1:0]      mux_r;
  logic [PIT_NUM_CH-1:0]      channel_irq_enable_r;
  logic [PIT_NUM_CH-1:0]      timeout_flag_r;
  logic [PIT_NUM_CH-1:0]      timeout_flag_nxt;
  logic [PIT_CNT_W-1:0]       load_value_bits_r [PIT_NUM_CH];
  logic [PIT_MT_W-1:0]        micro_timer_load_r [PIT_NUM_MT];
  logic [PIT_MT_W-1:0]        mt_cnt_r [PIT_NUM_MT];
  logic [PIT_NUM_TRIG-1:0]    trig_r;
  logic                       irq_r;

  // Bus slave state
  logic                       awready_r;
  logic                       wready_r;
  logic                       bvalid_r;
  logic [1:0]                 bresp_r;
  logic                       arready_r;
  logic                       rvalid_r;
  logic [31:0]                rdata_r;
  logic [1:0]                 rresp_r;
  logic                       aw_full_r;
  logic                       w_full_r;
  pit_wr_t                    wr_r;

  // Per-cycle decode results
  logic                       aw_take;
  logic                       w_take;
  logic                       ar_take;
  logic                       do_wr;
  logic [5:0]                 wr_idx;
  logic [31:0]                wd;
  logic                       wr_ctrl;
  logic                       wr_chen;
  logic                       wr_ie;
  logic [PIT_NUM_CH-1:0]      force_load_bits;
  logic [PIT_NUM_MT-1:0]      mt_force;
  logic [PIT_NUM_MT-1:0]      mt_tick;
  logic [PIT_NUM_CH-1:0]      ch_tick;
  logic [PIT_NUM_CH-1:0]      ch_timeout;
  logic [PIT_NUM_CH-1:0]      dis_clr;
  logic [PIT_NUM_CH-1:0]      w1c_clr;
  logic [PIT_CNT_W-1:0]       ch_count [PIT_NUM_CH];
  logic [31:0]                rd_word;

  assign aw_take = s_axi_awvalid & awready_r;
  assign w_take  = s_axi_wvalid & wready_r;
  assign ar_take = s_axi_arvalid & arready_r;
  // Commit only once both halves are held and the last response has gone
  assign do_wr   = aw_full_r & w_full_r & ~bvalid_r;
  assign wr_idx  = word_idx(wr_r.addr);
  assign wd      = wr_r.data;
  assign wr_ctrl = do_wr & (wr_r.addr == PIT_OFS_CTRL) & wr_r.strb[0];
  assign wr_chen = do_wr & (wr_r.addr == PIT_OFS_CHEN) & wr_r.strb[0];
  assign wr_ie   = do_wr & (wr_r.addr == PIT_OFS_IE) & wr_r.strb[0];

  // Write-address and write-data channels, accepted in either order
  always_ff @(posedge mclk) begin
    if (srst) begin
      aw_full_r <= 1'b0;
      awready_r <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_full_r <= 1'b1;
        awready_r <= 1'b0;
      end else if (do_wr) begin
        aw_full_r <= 1'b0;
        awready_r <= 1'b1;
      end else begin
        awready_r <= ~aw_full_r;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      w_full_r <= 1'b0;
      wready_r <= 1'b0;
    end else begin
      if (w_take) begin
        w_full_r <= 1'b1;
        wready_r <= 1'b0;
      end else if (do_wr) begin
        w_full_r <= 1'b0;
        wready_r <= 1'b1;
      end else begin
        wready_r <= ~w_full_r;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      wr_r <= '0;
    end else begin
      if (aw_take) begin
        wr_r.addr <= s_axi_awaddr;
      end
      if (w_take) begin
        wr_r.data <= s_axi_wdata;
        wr_r.strb <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      bvalid_r <= 1'b0;
      bresp_r  <= PIT_RESP_OKAY;
    end else if (do_wr) begin
      bvalid_r <= 1'b1;
      bresp_r  <= mapped(wr_r.addr) ? PIT_RESP_OKAY : PIT_RESP_SLVERR;
    end else if (bvalid_r & s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read channel; reads have no side effects
  always_comb begin
    rd_word = 32'h0000_0000;
    if (s_axi_araddr >= PIT_OFS_CNT_BASE) begin
      rd_word[15:0] = ch_count[s_axi_araddr[4:2]];
    end else if (s_axi_araddr >= PIT_OFS_LD_BASE) begin
      rd_word[15:0] = load_value_bits_r[s_axi_araddr[4:2]];
    end else begin
      unique case (s_axi_araddr)
        PIT_OFS_CTRL:  rd_word[PIT_CTRL_EN_BIT] = module_enable_r;
        PIT_OFS_CHEN:  rd_word[7:0] = channel_enable_r;
        PIT_OFS_MUX:   rd_word[7:0] = mux_r;
        PIT_OFS_IE:    rd_word[7:0] = channel_irq_enable_r;
        PIT_OFS_FLAG:  rd_word[7:0] = timeout_flag_r;
        PIT_OFS_MTLD0: rd_word[7:0] = micro_timer_load_r[0];
        PIT_OFS_MTLD1: rd_word[7:0] = micro_timer_load_r[1];
        default:       rd_word = 32'h0000_0000;
      endcase
    end
    if (!mapped(s_axi_araddr)) begin
      rd_word = 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= PIT_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r  <= 1'b1;
      arready_r <= 1'b0;
      rdata_r   <= rd_word;
      rresp_r   <= mapped(s_axi_araddr) ? PIT_RESP_OKAY : PIT_RESP_SLVERR;
    end else if (rvalid_r & s_axi_rready) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end else begin
      arready_r <= ~rvalid_r;
    end
  end

  // Control registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      module_enable_r      <= 1'b0;
      channel_enable_r     <= PIT_BYTE_RST;
      mux_r                <= PIT_BYTE_RST;
      channel_irq_enable_r <= PIT_BYTE_RST;
    end else begin
      if (wr_ctrl) begin
        module_enable_r <= wd[PIT_CTRL_EN_BIT];
      end
      if (wr_chen) begin
        channel_enable_r <= wd[7:0];
      end
      if (do_wr & (wr_r.addr == PIT_OFS_MUX) & wr_r.strb[0]) begin
        mux_r <= wd[7:0];
      end
      if (wr_ie) begin
        channel_irq_enable_r <= wd[7:0];
      end
    end
  end

  // Load values; a partial write would tear the value, so it is dropped
  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int i = 0; i < PIT_NUM_CH; i++) begin
        load_value_bits_r[i] <= PIT_LD_RST;
      end
      for (int m = 0; m < PIT_NUM_MT; m++) begin
        micro_timer_load_r[m] <= PIT_MTLD_RST;
      end
    end else if (do_wr) begin
      if (wr_r.addr[7:5] == PIT_OFS_LD_BASE[7:5] && wr_r.strb[1:0] == 2'b11) begin
        load_value_bits_r[wr_idx[2:0]] <= wd[15:0];
      end
      if (wr_r.addr == PIT_OFS_MTLD0 && wr_r.strb[0]) begin
        micro_timer_load_r[0] <= wd[7:0];
      end
      if (wr_r.addr == PIT_OFS_MTLD1 && wr_r.strb[0]) begin
        micro_timer_load_r[1] <= wd[7:0];
      end
    end
  end

  // Force-load strobes exist only in the cycle the write commits
  assign force_load_bits = (do_wr & (wr_r.addr == PIT_OFS_FORCE) & wr_r.strb[0]) ?
                           wd[7:0] : '0;
  assign mt_force = wr_ctrl ? wd[PIT_CTRL_FLMT_LO+1:PIT_CTRL_FLMT_LO] : '0;

  // Micro timers: the shared time base, ticking each time they pass zero
  always_comb begin
    for (int m = 0; m < PIT_NUM_MT; m++) begin
      mt_tick[m] = module_enable_r & ~mt_force[m] & (mt_cnt_r[m] == '0);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int m = 0; m < PIT_NUM_MT; m++) begin
        mt_cnt_r[m] <= PIT_MTLD_RST;
      end
    end else begin
      for (int m = 0; m < PIT_NUM_MT; m++) begin
        if (mt_force[m] || mt_tick[m]) begin
          mt_cnt_r[m] <= micro_timer_load_r[m];
        end else if (module_enable_r) begin
          mt_cnt_r[m] <= mt_cnt_r[m] - 8'h01;
        end
      end
    end
  end

  // Each channel picks one micro timer; disabled channels see no tick
  always_comb begin
    for (int i = 0; i < PIT_NUM_CH; i++) begin
      ch_tick[i] = module_enable_r & channel_enable_r[i] &
                   (mux_r[i] ? mt_tick[1] : mt_tick[0]);
    end
  end

  for (genvar g = 0; g < PIT_NUM_CH; g++) begin : g_chan
    pit_chan u_chan (
      .mclk       (mclk),
      .srst       (srst),
      .tick       (ch_tick[g]),
      .force_load (force_load_bits[g]),
      .load_val   (load_value_bits_r[g]),
      .count      (ch_count[g]),
      .timeout    (ch_timeout[g])
    );
  end

  // Flag clearing: write-one, or an enable bit going from one to zero
  always_comb begin
    w1c_clr = '0;
    dis_clr = '0;
    if (do_wr && wr_r.addr == PIT_OFS_FLAG && wr_r.strb[0]) begin
      w1c_clr = wd[7:0];
    end
    if (wr_chen) begin
      dis_clr = dis_clr | (channel_enable_r & ~wd[7:0]);
    end
    if (wr_ie) begin
      dis_clr = dis_clr | (channel_irq_enable_r & ~wd[7:0]);
    end
    if (wr_ctrl && module_enable_r && !wd[PIT_CTRL_EN_BIT]) begin
      dis_clr = '1;
    end
    // A time-out in the clearing cycle survives: set beats clear
    timeout_flag_nxt = (timeout_flag_r & ~w1c_clr & ~dis_clr) | ch_timeout;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      timeout_flag_r <= PIT_BYTE_RST;
    end else begin
      timeout_flag_r <= timeout_flag_nxt;
    end
  end

  // Trigger goes high for one clock per time-out; back-to-back time-outs
  // would merge, hence the two-cycle minimum period on software's side
  always_ff @(posedge mclk) begin
    if (srst) begin
      trig_r <= '0;
    end else begin
      trig_r <= ch_timeout[PIT_NUM_TRIG-1:0];
    end
  end

  // Level request, one clock behind the flag
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(timeout_flag_r & channel_irq_enable_r);
    end
  end

  assign s_axi_awready  = awready_r;
  assign s_axi_wready   = wready_r;
  assign s_axi_bvalid   = bvalid_r;
  assign s_axi_bresp    = bresp_r;
  assign s_axi_arready  = arready_r;
  assign s_axi_rvalid   = rvalid_r;
  assign s_axi_rdata    = rdata_r;
  assign s_axi_rresp    = rresp_r;
  assign hw_trigger_out = trig_r;
  assign irq            = irq_r;

endmodule : pit_top

// ---- tb/pit_adc_model.sv ----
// Stand-in for a converter that starts one conversion per trigger edge.
// Assumes the trigger lines come straight from pit_top on mclk.
`timescale 1ns/100ps
module pit_adc_model
  import pit_pkg::*;
(
  input  wire logic                         mclk,
  input  wire logic                         srst,
  input  wire logic [PIT_NUM_TRIG-1:0]      hw_trigger_out,
  output logic      [PIT_NUM_TRIG-1:0][7:0] starts
);
  logic [PIT_NUM_TRIG-1:0] trig_d_r;

  always_ff @(posedge mclk) begin
    trig_d_r <= srst ? '0 : hw_trigger_out;
    for (int i = 0; i < PIT_NUM_TRIG; i++) begin
      if (srst) begin
        starts[i] <= 8'h00;
      end else if (hw_trigger_out[i] && !trig_d_r[i]) begin
        starts[i] <= starts[i] + 8'h01;
      end
    end
  end
endmodule : pit_adc_model

// ---- tb/pit_top_sva.sv ----
// Port-level checker for the timer: bus answers and trigger pulses.
// Assumes only the ports of pit_top; bound below.
`timescale 1ns/100ps
module pit_chk
  import pit_pkg::*;
(
  input wire logic                    mclk,
  input wire logic                    srst,
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_awready,
  input wire logic                    s_axi_wvalid,
  input wire logic                    s_axi_wready,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_bready,
  input wire logic [1:0]              s_axi_bresp,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic [PIT_ADDR_W-1:0]   s_axi_araddr,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_rready,
  input wire logic [31:0]             s_axi_rdata,
  input wire logic [1:0]              s_axi_rresp,
  input wire logic [PIT_NUM_TRIG-1:0] hw_trigger_out,
  input wire logic                    irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  logic rst_seen_r;

  always_ff @(posedge mclk) begin
    rst_seen_r <= srst;
  end

  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_wr_answer: assert property (s_wr_taken |-> ##[2:4] s_axi_bvalid)
    else $error("write answer missing");
  a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read answer missing");
  a_wr_blocked: assert property (s_wr_taken |=> !s_axi_awready && !s_axi_wready)
    else $error("write taken twice");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  a_hole_read: assert property (s_rd_taken ##0 (s_axi_araddr >= PIT_OFS_END)
    |=> s_axi_rresp == PIT_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_trig_pulse: assert property ($rose(hw_trigger_out[0]) |=> !hw_trigger_out[0])
    else $error("trigger 0 pulse too long");
  a_trig1_pulse: assert property ($rose(hw_trigger_out[1]) |=> !hw_trigger_out[1])
    else $error("trigger 1 pulse too long");
  a_rst_quiet: assert property (rst_seen_r |-> !irq && hw_trigger_out == '0 && !s_axi_bvalid)
    else $error("outputs busy after reset");
endmodule : pit_chk

bind pit_top pit_chk u_chk (
  .mclk(mclk), .srst(srst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .hw_trigger_out(hw_trigger_out), .irq(irq)
);

// ---- tb/tb.sv ----
// Self-checking bench for pit_top with a converter model on the triggers.
// Assumes a 10 MHz mclk and AXI4-Lite master tasks driven from here.
`timescale 1ns/100ps
module tb
  import pit_pkg::*;
;
  logic                         mclk, srst, irq;
  logic                         awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr;
  logic [7:0]                   awa, ara;
  logic [31:0]                  wd, rdata;
  logic [3:0]                   ws;
  logic [1:0]                   bresp, rresp;
  logic [PIT_NUM_TRIG-1:0]      trig;
  logic [PIT_NUM_TRIG-1:0][7:0] starts;
  int                           fail_count, num_checks, cyc;

  pit_top u_dut (
    .mclk(mclk), .srst(srst), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_awprot(3'b000), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_arprot(3'b000), .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .hw_trigger_out(trig), .irq(irq)
  );
  pit_adc_model u_adc (.mclk(mclk), .srst(srst), .hw_trigger_out(trig), .starts(starts));

  task automatic report_and_stop();
    if (fail_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Response ready rises with the request and is held until the answer is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    bit ap;
    bit dp;
    ap = 1;
    dp = 1;
    awa <= a;
    wd <= d;
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge mclk);
      if (ap && awr === 1'b1) begin
        ap = 0;
        awv <= 1'b0;
      end
      if (dp && wrdy === 1'b1) begin
        dp = 0;
        wv <= 1'b0;
      end
    end while (ap || dp);
    do @(posedge mclk); while (bv !== 1'b1);
    chk(bresp, er);
    br <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do @(posedge mclk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge mclk); while (rv !== 1'b1);
    d = rdata;
    chk(rresp, (a >= PIT_OFS_END) ? PIT_RESP_SLVERR : PIT_RESP_OKAY);
    rr <= 1'b0;
    @(posedge mclk);
  endtask : rd

  task automatic trig_gap(input int ch, input int exp_gap);
    int gap;
    int hi;
    logic [7:0] s0;
    gap = 0;
    hi = 0;
    do @(posedge mclk); while (trig[ch] !== 1'b1);
    s0 = starts[ch];
    while (trig[ch] === 1'b1) begin
      @(posedge mclk);
      hi++;
      gap++;
    end
    while (trig[ch] !== 1'b1) begin
      @(posedge mclk);
      gap++;
    end
    chk(gap, exp_gap);
    chk(hi, 1);
    chk(8'(starts[ch] - s0), 32'h1);
  endtask : trig_gap

  task automatic t_regs();
    logic [31:0] d;
    for (int i = 0; i < PIT_NUM_CH; i++) begin
      rd(PIT_OFS_LD_BASE + 8'(4 * i), d);
      chk(d, {16'h0000, PIT_LD_RST});
    end
    wr(PIT_OFS_LD_BASE, 32'hdead_beef, 4'hf, PIT_RESP_OKAY);
    rd(PIT_OFS_LD_BASE, d);
    chk(d, 32'h0000_beef);
    // Single-byte write is not a whole load update and must be dropped
    wr(PIT_OFS_LD_BASE, 32'h0000_1234, 4'h1, PIT_RESP_OKAY);
    rd(PIT_OFS_LD_BASE, d);
    chk(d, 32'h0000_beef);
    rd(PIT_OFS_CNT_BASE, d);
    chk(d, 32'h0);
    wr(PIT_OFS_END, 32'h1, 4'hf, PIT_RESP_SLVERR);
    rd(PIT_OFS_END, d);
    chk(d, 32'h0);
  endtask : t_regs

  task automatic t_period();
    logic [31:0] d;
    wr(PIT_OFS_MTLD1, 32'h0f, 4'hf, PIT_RESP_OKAY);
    wr(PIT_OFS_MUX, 32'h02, 4'hf, PIT_RESP_OKAY);
    wr(PIT_OFS_LD_BASE, 32'h3, 4'hf, PIT_RESP_OKAY);
    wr(PIT_OFS_LD_BASE + 8'h04, 32'h1, 4'hf, PIT_RESP_OKAY);
    wr(PIT_OFS_FORCE, 32'h03, 4'hf, PIT_RESP_OKAY);
    rd(PIT_OFS_CNT_BASE, d);
    chk(d, 32'h3);
    wr(PIT_OFS_IE, 32'h02, 4'hf, PIT_RESP_OKAY);
    wr(PIT_OFS_CHEN, 32'h03, 4'hf, PIT_RESP_OKAY);
    wr(PIT_OFS_CTRL, 32'h80, 4'hf, PIT_RESP_OKAY);
    trig_gap(0, 4);
    trig_gap(1, 32);
    // Write just after a time-out: the old count must still run out on time
    do @(posedge mclk); while (trig[0] !== 1'b1);
    wr(PIT_OFS_LD_BASE, 32'h5, 4'hf, PIT_RESP_OKAY);
    chk(trig[0], 1'b1);
    trig_gap(0, 6);
    chk(starts[3:2], 16'h0000);
  endtask : t_period

  task automatic t_irq();
    logic [31:0] d;
    logic [31:0] d2;
    do @(posedge mclk); while (irq !== 1'b1);
    wr(PIT_OFS_FLAG, 32'h00, 4'hf, PIT_RESP_OKAY);
    rd(PIT_OFS_FLAG, d);
    chk(d & 32'h2, 32'h2);
    chk(irq, 1'b1);
    // Clear just after a channel 1 time-out so no new one lands before the read
    do @(posedge mclk); while (trig[1] !== 1'b1);
    wr(PIT_OFS_FLAG, 32'h02, 4'hf, PIT_RESP_OKAY);
    rd(PIT_OFS_FLAG, d);
    chk(d & 32'h2, 32'h0);
    chk(irq, 1'b0);
    do @(posedge mclk); while (irq !== 1'b1);
    wr(PIT_OFS_IE, 32'h00, 4'hf, PIT_RESP_OKAY);
    rd(PIT_OFS_FLAG, d);
    chk(d & 32'h2, 32'h0);
    chk(irq, 1'b0);
    wr(PIT_OFS_IE, 32'h02, 4'hf, PIT_RESP_OKAY);
    do @(posedge mclk); while (irq !== 1'b1);
    wr(PIT_OFS_CHEN, 32'h01, 4'hf, PIT_RESP_OKAY);
    rd(PIT_OFS_FLAG, d);
    chk(d & 32'h2, 32'h0);
    // A time-out in the disabling cycle would win over the clear
    do @(posedge mclk); while (trig[0] !== 1'b1);
    wr(PIT_OFS_CTRL, 32'h00, 4'hf, PIT_RESP_OKAY);
    rd(PIT_OFS_FLAG, d);
    chk(d, 32'h0);
    rd(PIT_OFS_CNT_BASE, d);
    wr(PIT_OFS_FLAG, 32'h00, 4'hf, PIT_RESP_OKAY);
    rd(PIT_OFS_CNT_BASE, d2);
    chk(d2, d);
    chk(trig, 4'h0);
  endtask : t_irq

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Cuts a hang short well past the few hundred cycles the run needs
  initial begin
    cyc = 0;
    forever begin
      @(posedge mclk);
      cyc++;
      if (cyc >= 20000) begin
        fail_count++;
        report_and_stop();
      end
    end
  end

  initial begin
    {srst, awv, wv, br, arv, rr} = 6'b100000;
    {awa, ara, wd, ws} = '0;
    fail_count = 0;
    num_checks = 0;
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    t_regs();
    t_period();
    t_irq();
    report_and_stop();
  end
endmodule : tb
